// ---- common/qsq_pkg.sv ----
// constants and carrier types of the queued serial queue memory
// assumes one system clock; the cpu and the serial engine share it
// How it works
// - received words stored right-justified, lsb rightmost
// - bits above transfer length cleared on completion
// - receive section readable as byte, half, word
// - status shows completed queue pointer
// - engine only reads transmit section
// - command section used in master mode, unmodified
// - 32 command bytes: chip-select and control fields
// - queue entries addressed 0x00 to 0x1F
// - run from start pointer through end pointer
package qsq_pkg;
	localparam int QUEUE_DEPTH = 32;
	localparam int PTR_W       = 5;
	localparam int WORD_W      = 16;
	localparam int LEN_W       = 5;
	localparam logic [PTR_W-1:0] PTR_FIRST = 5'h00;
	localparam logic [PTR_W-1:0] PTR_LAST  = 5'h1F;
	// cpu address: [7:6] section, [5:0] byte offset inside it
	localparam int ADDR_W     = 8;
	localparam int SEC_HI     = 7;
	localparam int SEC_LO     = 6;
	localparam logic [1:0] SEC_RX  = 2'h0;
	localparam logic [1:0] SEC_TX  = 2'h1;
	localparam logic [1:0] SEC_CMD = 2'h2;
	// access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// command byte layout
	localparam int CMD_PCS_LO   = 0;
	localparam int CMD_PCS_W    = 4;
	localparam int CMD_CONT_BIT = 7;
	localparam int CMD_BITSE    = 6;
	localparam logic [LEN_W-1:0] LEN_DEFAULT = 5'h08;
	localparam logic [LEN_W-1:0] LEN_MAX     = 5'h10;
	localparam logic [CMD_PCS_W-1:0] PCS_IDLE = 4'hF;
	// serial clock: system clock divided by twice this count
	localparam int SCK_HALF_DIV = 2;

	typedef struct packed {
		logic [PTR_W-1:0]  idx;
		logic [WORD_W-1:0] data;
	} qsq_rx_item_t;

	typedef struct packed {
		logic             done;
		logic             busy;
		logic [PTR_W-1:0] completed_queue_pointer;
	} qsq_status_t;
endpackage : qsq_pkg

// ---- design/qsq_buf2.sv ----
// two-entry buffer with valid/ready on both sides
// assumes both sides on the system clock
`timescale 1ns/1ps
module qsq_buf2 #(
	parameter int W = 8
) (
	input  wire logic         CLK,
	input  wire logic         RESET,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem [2];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	assign in_ready  = count != 2'h2;
	assign out_valid = count != 2'h0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge CLK) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule : qsq_buf2

// ---- design/qsq_shifter.sv ----
// master serializer: makes the serial clock, shifts msb first
// assumes mode 0 (clock idles low, sample on rising edge); miso is asynchronous
`timescale 1ns/1ps
module qsq_shifter #(
	parameter int W        = qsq_pkg::WORD_W,
	parameter int HALF_DIV = qsq_pkg::SCK_HALF_DIV
) (
	input  wire logic                     CLK,
	input  wire logic                     RESET,
	input  wire logic                     start,
	input  wire logic [qsq_pkg::LEN_W-1:0] len,
	input  wire logic [W-1:0]             tx_word,
	input  wire logic                     miso_pin,
	output logic                          sck,
	output logic                          mosi,
	output logic                          done,
	output logic [W-1:0]                  rx_word
);
	logic [W-1:0]                sr;
	logic [qsq_pkg::LEN_W-1:0]   cnt;
	logic [7:0]                  div;
	logic                        active;
	logic                        miso_meta;
	logic                        miso_sync;
	wire                         tick = active && (div == 8'(HALF_DIV - 1));

	assign mosi = sr[W-1];

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			miso_meta <= 1'b0;
			miso_sync <= 1'b0;
		end else begin
			miso_meta <= miso_pin;
			miso_sync <= miso_meta;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sr      <= '0;
			rx_word <= '0;
			cnt     <= '0;
			div     <= '0;
			active  <= 1'b0;
			sck     <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !active) begin
				// left-align the right-justified word so its top bit leaves first
				sr      <= tx_word << (W - int'(len));
				rx_word <= '0;
				cnt     <= '0;
				div     <= '0;
				active  <= 1'b1;
			end else if (active) begin
				div <= tick ? 8'h00 : div + 8'h01;
				if (tick) begin
					sck <= ~sck;
					if (!sck) begin
						cnt <= cnt + 5'h01;
					end else begin
						// the bit on the pin at the rising edge clears the two flops only now
						rx_word <= {rx_word[W-2:0], miso_sync};
						sr      <= sr << 1;
						if (cnt == len) begin
							active <= 1'b0;
							done   <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule : qsq_shifter

// ---- design/qsq_queue_ram.sv ----
// queue memory and queue engine of the queued serial master
// assumes cpu accesses are single-cycle strobes on the system clock; pins are asynchronous
`timescale 1ns/1ps
module qsq_queue_ram #(
	parameter int DEPTH    = qsq_pkg::QUEUE_DEPTH,
	parameter int W        = qsq_pkg::WORD_W,
	parameter int HALF_DIV = qsq_pkg::SCK_HALF_DIV
) (
	input  wire logic                              CLK,
	input  wire logic                              RESET,
	input  wire logic                              CPU_RE,
	input  wire logic                              CPU_WE,
	input  wire logic [qsq_pkg::ADDR_W-1:0]         CPU_ADDR,
	input  wire logic [1:0]                        CPU_SIZE,
	input  wire logic [31:0]                       CPU_WDATA,
	output logic [31:0]                            CPU_RDATA,
	output logic                                   CPU_RVALID,
	input  wire logic                              MASTER,
	input  wire logic                              START,
	input  wire logic [qsq_pkg::PTR_W-1:0]          QUEUE_START_POINTER,
	input  wire logic [qsq_pkg::PTR_W-1:0]          QUEUE_END_POINTER,
	input  wire logic [qsq_pkg::LEN_W-1:0]          BITS,
	output qsq_pkg::qsq_status_t                   SERIAL_STATUS_REGISTER,
	output logic [qsq_pkg::CMD_PCS_W-1:0]           PCS,
	output logic                                   SCK,
	output logic                                   MOSI,
	input  wire logic                              MISO
);
	typedef enum logic [2:0] {QSQ_IDLE, QSQ_LOAD, QSQ_SHIFT, QSQ_PUSH, QSQ_DRAIN} qsq_state_t;

	logic [W-1:0]                  rx_ram  [DEPTH];
	logic [W-1:0]                  tx_ram  [DEPTH];
	logic [7:0]                    cmd_ram [DEPTH];
	qsq_state_t                    state;
	qsq_state_t                    next_state;
	logic [qsq_pkg::PTR_W-1:0]     ptr;
	logic [qsq_pkg::PTR_W-1:0]     end_ptr;
	logic [qsq_pkg::PTR_W-1:0]     completed;
	logic                          done_flag;
	logic [qsq_pkg::LEN_W-1:0]     cur_len;
	logic [7:0]                    cur_cmd;
	logic [W-1:0]                  masked;
	logic                          sh_start;
	logic                          sh_done;
	logic [W-1:0]                  sh_rx;
	logic                          push_valid;
	logic                          push_ready;
	qsq_pkg::qsq_rx_item_t         push_item;
	logic                          pop_valid;
	logic                          pop_ready;
	qsq_pkg::qsq_rx_item_t         pop_item;
	logic [W-1:0]                  mask;

	// mask keeping the low len bits
	function automatic logic [W-1:0] len_mask(input logic [qsq_pkg::LEN_W-1:0] len);
		logic [W:0] one;
		one = '0;
		one[len] = 1'b1;
		return W'(one - (W+1)'(1));
	endfunction : len_mask

	// transfer length of one entry: programmed length when the command asks, else a byte
	function automatic logic [qsq_pkg::LEN_W-1:0] entry_len_of(input logic [7:0] cmd,
		input logic [qsq_pkg::LEN_W-1:0] bits);
		if (!cmd[qsq_pkg::CMD_BITSE])
			return qsq_pkg::LEN_DEFAULT;
		return (bits == 5'h00) ? qsq_pkg::LEN_MAX : bits;
	endfunction : entry_len_of

	// entry index from a byte offset inside a halfword section
	function automatic logic [qsq_pkg::PTR_W-1:0] half_idx(input logic [5:0] off);
		return off[5:1];
	endfunction : half_idx

	// address map seen by the cpu:
	//   section 0: receive words, 16 bits each, two bytes per entry
	//   section 1: transmit words, 16 bits each, two bytes per entry
	//   section 2: command bytes, one byte per entry
	//   section 3: unused, reads give zero and writes are dropped
	// the receive section takes no cpu writes; only the engine fills it
	// the transmit and command sections are never written by the engine,
	// so one queue can be rerun without software reloading it
	// cpu decode
	wire [1:0]                 sec      = CPU_ADDR[qsq_pkg::SEC_HI:qsq_pkg::SEC_LO];
	wire [5:0]                 off      = CPU_ADDR[5:0];
	wire [qsq_pkg::PTR_W-1:0]  hidx     = half_idx(off);
	wire [qsq_pkg::PTR_W-1:0]  hidx_nxt = hidx + 5'h01;
	wire [qsq_pkg::PTR_W-1:0]  bidx     = off[4:0];
	wire                       wr_tx    = CPU_WE && sec == qsq_pkg::SEC_TX;
	wire                       wr_cmd   = CPU_WE && sec == qsq_pkg::SEC_CMD;
	wire                       rd_rx    = CPU_RE && sec == qsq_pkg::SEC_RX;

	// receive section: byte, half and word views, big-endian lanes
	wire [W-1:0]  rx_half  = rx_ram[hidx];
	wire [7:0]    rx_byte  = off[0] ? rx_half[7:0] : rx_half[15:8];
	wire [31:0]   rx_word  = {rx_ram[hidx], rx_ram[hidx_nxt]};
	wire [31:0]   rx_view  = (CPU_SIZE == qsq_pkg::SIZE_BYTE) ? {24'h00_0000, rx_byte} :
	                         (CPU_SIZE == qsq_pkg::SIZE_HALF) ? {16'h0000, rx_half} :
	                         rx_word;
	wire [31:0]   tx_view  = {16'h0000, tx_ram[hidx]};
	wire [31:0]   cmd_view = {24'h00_0000, cmd_ram[bidx]};
	wire [31:0]   rd_mux   = rd_rx ? rx_view :
	                         (sec == qsq_pkg::SEC_TX) ? tx_view :
	                         (sec == qsq_pkg::SEC_CMD) ? cmd_view : 32'h0000_0000;

	// current queue entry
	wire          last_entry = ptr == end_ptr;
	// decoded from the latched command, so it is valid at the edge that starts the shifter
	wire [qsq_pkg::LEN_W-1:0] entry_len = entry_len_of(cur_cmd, BITS);

	assign mask       = len_mask(cur_len);
	assign masked     = sh_rx & mask;
	assign sh_start   = state == QSQ_LOAD;
	assign push_valid = state == QSQ_PUSH;
	assign push_item  = '{idx: ptr, data: masked};
	// cpu reads of the receive section take the ram port first
	assign pop_ready  = !rd_rx;

	assign SERIAL_STATUS_REGISTER = '{done: done_flag, busy: state != QSQ_IDLE,
	                                  completed_queue_pointer: completed};

	// one entry per pass: load latches the command and starts the shifter,
	// shift waits for the last falling serial edge, push hands the masked
	// word to the buffer; after the end entry the engine drains the buffer
	// before it reports done, so a finished queue has every word in the ram.
	// a stall by the buffer only holds push; no received word is lost.
	// limitation: the length input is read live during each entry, so it
	// must not change while the queue runs
	always_comb begin
		next_state = state;
		unique case (state)
			QSQ_IDLE:
				if (START && MASTER) begin
					next_state = QSQ_LOAD;
				end
			QSQ_LOAD:
				next_state = QSQ_SHIFT;
			QSQ_SHIFT:
				if (sh_done) begin
					next_state = QSQ_PUSH;
				end
			QSQ_PUSH:
				if (push_ready) begin
					next_state = last_entry ? QSQ_DRAIN : QSQ_LOAD;
				end
			QSQ_DRAIN:
				if (!pop_valid) begin
					next_state = QSQ_IDLE;
				end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state   <= QSQ_IDLE;
			ptr     <= qsq_pkg::PTR_FIRST;
			end_ptr <= qsq_pkg::PTR_LAST;
			cur_cmd <= 8'h00;
			cur_len <= qsq_pkg::LEN_DEFAULT;
			PCS     <= qsq_pkg::PCS_IDLE;
		end else begin
			state <= next_state;
			if (state == QSQ_IDLE && START && MASTER) begin
				ptr     <= QUEUE_START_POINTER;
				end_ptr <= QUEUE_END_POINTER;
			end
			if (next_state == QSQ_LOAD) begin
				// entries only read: command and transmit sections stay as software wrote them
				cur_cmd <= cmd_ram[(state == QSQ_IDLE) ? QUEUE_START_POINTER : ptr + 5'h01];
			end
			if (state == QSQ_LOAD) begin
				cur_len <= entry_len;
				PCS     <= cur_cmd[qsq_pkg::CMD_PCS_LO +: qsq_pkg::CMD_PCS_W];
			end
			if (state == QSQ_PUSH && push_ready) begin
				if (!cur_cmd[qsq_pkg::CMD_CONT_BIT] || last_entry)
					PCS <= qsq_pkg::PCS_IDLE;
				ptr <= ptr + 5'h01;
			end
		end
	end

	// status: completed pointer follows the receive writes, done holds till next start
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			completed <= qsq_pkg::PTR_FIRST;
			done_flag <= 1'b0;
		end else begin
			if (pop_valid && pop_ready)
				completed <= pop_item.idx;
			if (state == QSQ_DRAIN && !pop_valid)
				done_flag <= 1'b1;
			else if (state == QSQ_IDLE && START && MASTER)
				done_flag <= 1'b0;
		end
	end

	// memories carry no reset: transmit and command contents are whatever software wrote,
	// and the receive words are meaningful only up to the completed pointer
	always_ff @(posedge CLK) begin
		if (pop_valid && pop_ready)
			rx_ram[pop_item.idx] <= pop_item.data;
		if (wr_tx)
			tx_ram[hidx] <= CPU_WDATA[W-1:0];
		if (wr_cmd)
			cmd_ram[bidx] <= CPU_WDATA[7:0];
	end

	// read answer one cycle after the strobe; data holds until the next read
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			CPU_RDATA  <= 32'h0000_0000;
			CPU_RVALID <= 1'b0;
		end else begin
			CPU_RVALID <= CPU_RE;
			if (CPU_RE)
				CPU_RDATA <= rd_mux;
		end
	end

	qsq_shifter #(
		.W        (W),
		.HALF_DIV (HALF_DIV)
	) u_shifter (
		.CLK      (CLK),
		.RESET    (RESET),
		.start    (sh_start),
		.len      (entry_len),
		.tx_word  (tx_ram[ptr]),
		.miso_pin (MISO),
		.sck      (SCK),
		.mosi     (MOSI),
		.done     (sh_done),
		.rx_word  (sh_rx)
	);

	// received words wait here while a cpu read holds the receive ram port;
	// two entries cover one stalled push while the next entry is shifting
	qsq_buf2 #(
		.W (qsq_pkg::PTR_W + W)
	) u_rx_buf (
		.CLK       (CLK),
		.RESET     (RESET),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_item),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_item)
	);
endmodule : qsq_queue_ram

// ---- verif/qsq_queue_ram_sva.sv ----
// concurrent checks on the queue memory top ports
// assumes a bind from the testbench top file
`timescale 1ns/1ps
module qsq_queue_ram_sva #(
	parameter int DEPTH    = 32,
	parameter int W        = 16,
	parameter int HALF_DIV = 2
) (
	input wire logic                         CLK,
	input wire logic                         RESET,
	input wire logic                         CPU_RE,
	input wire logic                         CPU_WE,
	input wire logic [qsq_pkg::ADDR_W-1:0]   CPU_ADDR,
	input wire logic [1:0]                   CPU_SIZE,
	input wire logic [31:0]                  CPU_WDATA,
	input wire logic [31:0]                  CPU_RDATA,
	input wire logic                         CPU_RVALID,
	input wire logic                         MASTER,
	input wire logic                         START,
	input wire logic [qsq_pkg::PTR_W-1:0]    QUEUE_START_POINTER,
	input wire logic [qsq_pkg::PTR_W-1:0]    QUEUE_END_POINTER,
	input wire logic [qsq_pkg::LEN_W-1:0]    BITS,
	input wire qsq_pkg::qsq_status_t         SERIAL_STATUS_REGISTER,
	input wire logic [qsq_pkg::CMD_PCS_W-1:0] PCS,
	input wire logic                         SCK,
	input wire logic                         MOSI,
	input wire logic                         MISO
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	wire logic       busy = SERIAL_STATUS_REGISTER.busy;
	wire logic       done = SERIAL_STATUS_REGISTER.done;
	wire logic [4:0] cqp  = SERIAL_STATUS_REGISTER.completed_queue_pointer;

	property p_rvalid_follows; CPU_RVALID == $past(CPU_RE); endproperty
	a_rvalid_follows: assert property (p_rvalid_follows)
		else $error("read answer not one cycle after strobe");
	property p_refuse_slave; !MASTER && !busy |=> !busy; endproperty
	a_refuse_slave: assert property (p_refuse_slave)
		else $error("queue ran while not master");
	property p_start_taken; START && MASTER && !busy |-> ##[1:4] busy; endproperty
	a_start_taken: assert property (p_start_taken)
		else $error("start not taken");
	property p_pcs_only_busy; PCS != qsq_pkg::PCS_IDLE |-> busy || $past(busy); endproperty
	a_pcs_only_busy: assert property (p_pcs_only_busy)
		else $error("chip select active while idle");
	property p_sck_quiet; !busy [*3] |-> !SCK; endproperty
	a_sck_quiet: assert property (p_sck_quiet)
		else $error("serial clock moved while idle");
	property p_sck_half; $rose(SCK) |=> SCK ##1 !SCK; endproperty
	a_sck_half: assert property (p_sck_half)
		else $error("serial clock high time wrong");
	property p_done_from_busy; $rose(done) |-> $past(busy); endproperty
	a_done_from_busy: assert property (p_done_from_busy)
		else $error("done without a run");
	property p_ptr_hold; (done && !busy) ##1 (done && !busy) |-> $stable(cqp); endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("completed pointer moved after finish");
endmodule : qsq_queue_ram_sva

// ---- verif/qsq_spi_peer.sv ----
// behavioural serial peripheral, mode 0, replies from a fixed bit stream
// assumes chip selects all high mean no frame
`timescale 1ns/1ps
module qsq_spi_peer #(
	parameter logic [63:0] REPLY = 64'hC3A5_96E1_7B2D_4F08
) (
	input wire logic [3:0] pcs,
	input wire logic       sck,
	input wire logic       mosi,
	output logic           miso,
	output int             bit_cnt,
	output logic [63:0]    mosi_log
);
	initial begin
		bit_cnt = 0;
		mosi_log = 64'h0000_0000_0000_0000;
		miso = 1'b0;
	end
	// log every sampled bit across frames; the bench slices it per entry
	always @(posedge sck) begin
		mosi_log <= {mosi_log[62:0], mosi};
		bit_cnt <= bit_cnt + 1;
	end
	// out of frame the line toggles so a stale value is never mistaken for data
	always @(negedge sck or pcs) begin
		miso <= (pcs == 4'hF) ? ~miso : REPLY[63 - (bit_cnt % 64)];
	end
endmodule : qsq_spi_peer

// ---- verif/testbench.sv ----
// self-checking bench for the queue memory and its engine
// assumes the peer model and the checker are compiled before it
`timescale 1ns/1ps
module testbench;
	localparam logic [63:0] REPLY = 64'hC3A5_96E1_7B2D_4F08;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        re = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [1:0]  size = 2'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        master = 1'b0;
	logic        start = 1'b0;
	logic [4:0]  sp = 5'h00;
	logic [4:0]  ep = 5'h00;
	logic [4:0]  bits = 5'h0C;
	logic [31:0] rdata;
	logic        rvalid;
	logic [3:0]  pcs;
	logic        sck;
	logic        mosi;
	logic        miso;
	int          bit_cnt;
	logic [63:0] mosi_log;
	int          errors = 0;
	int          cmp_count = 0;
	logic [15:0] tx [3] = '{16'hA5C3, 16'h3C96, 16'h5AE7};
	qsq_pkg::qsq_status_t status;

	qsq_queue_ram DUT (.CLK(clk), .RESET(reset), .CPU_RE(re), .CPU_WE(we), .CPU_ADDR(addr),
		.CPU_SIZE(size), .CPU_WDATA(wdata), .CPU_RDATA(rdata), .CPU_RVALID(rvalid),
		.MASTER(master), .START(start), .QUEUE_START_POINTER(sp), .QUEUE_END_POINTER(ep),
		.BITS(bits), .SERIAL_STATUS_REGISTER(status), .PCS(pcs), .SCK(sck), .MOSI(mosi),
		.MISO(miso));
	qsq_spi_peer #(.REPLY(REPLY)) peer (.pcs(pcs), .sck(sck), .mosi(mosi), .miso(miso),
		.bit_cnt(bit_cnt), .mosi_log(mosi_log));

	initial forever #5 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] rx_exp(input int p, input int len);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < len; i++) v = {v[30:0], REPLY[63 - p - i]};
		return v;
	endfunction : rx_exp

	task automatic cpu_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask : cpu_wr

	task automatic cpu_rd(input logic [7:0] a, input logic [1:0] sz, output logic [31:0] d);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		size <= sz;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask : cpu_rd

	// waits past the first cycles so a done left from the last run is not taken
	task automatic run(input logic [4:0] s, input logic [4:0] e);
		int n;
		@(posedge clk);
		sp <= s;
		ep <= e;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		#1;
		while (!(status.done === 1'b1 && status.busy === 1'b0 && n > 2) && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 3000) chk(32'h0000_0000, 32'h0000_0001);
		chk(32'(status), {25'h0, 1'b1, 1'b0, e});
	endtask : run

	task automatic t_reset;
		chk({27'h0, pcs, sck}, {27'h0, qsq_pkg::PCS_IDLE, 1'b0});
		chk(32'(status), 32'h0000_0000);
	endtask : t_reset

	task automatic t_refuse;
		@(posedge clk);
		start <= 1'b1;
		repeat (10) @(posedge clk);
		start <= 1'b0;
		#1 chk({27'h0, pcs, status.busy}, {27'h0, qsq_pkg::PCS_IDLE, 1'b0});
		master <= 1'b1;
	endtask : t_refuse

	task automatic t_queue;
		logic [31:0] d;
		cpu_wr(8'h9E, 32'h0000_0042);
		cpu_wr(8'h9F, 32'h0000_0005);
		cpu_wr(8'h80, 32'h0000_0046);
		cpu_wr(8'h7C, {16'h0000, tx[0]});
		cpu_wr(8'h7E, {16'h0000, tx[1]});
		cpu_wr(8'h40, {16'h0000, tx[2]});
		run(5'h1E, 5'h00);
		cpu_rd(8'h3C, qsq_pkg::SIZE_WORD, d);
		chk(d, (rx_exp(0, 12) << 16) | rx_exp(12, 8));
		cpu_rd(8'h3D, qsq_pkg::SIZE_BYTE, d);
		chk(d, rx_exp(0, 12) & 32'h0000_00FF);
		cpu_rd(8'h00, qsq_pkg::SIZE_HALF, d);
		chk(d, rx_exp(20, 12));
		chk(mosi_log[31:0], {tx[0][11:0], tx[1][7:0], tx[2][11:0]});
		cpu_wr(8'h3C, 32'h0000_FFFF);
		cpu_rd(8'h3C, qsq_pkg::SIZE_HALF, d);
		chk(d, rx_exp(0, 12));
	endtask : t_queue

	// rerun of one entry: transmit word must still be there, full length this time
	task automatic t_rerun;
		logic [31:0] d;
		bits <= 5'h00;
		run(5'h1E, 5'h1E);
		cpu_rd(8'h3C, qsq_pkg::SIZE_HALF, d);
		chk(d, rx_exp(32, 16));
		chk({16'h0000, mosi_log[15:0]}, {16'h0000, tx[0]});
		chk(32'(bit_cnt), 32'h0000_0030);
	endtask : t_rerun

	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	initial begin
		#200000;
		errors++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1 t_reset();
		t_refuse();
		t_queue();
		t_rerun();
		close_out();
	end
endmodule : testbench

bind qsq_queue_ram qsq_queue_ram_sva #(.DEPTH(DEPTH), .W(W), .HALF_DIV(HALF_DIV)) u_sva (
	.CLK(CLK), .RESET(RESET), .CPU_RE(CPU_RE), .CPU_WE(CPU_WE), .CPU_ADDR(CPU_ADDR),
	.CPU_SIZE(CPU_SIZE), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA),
	.CPU_RVALID(CPU_RVALID), .MASTER(MASTER), .START(START),
	.QUEUE_START_POINTER(QUEUE_START_POINTER), .QUEUE_END_POINTER(QUEUE_END_POINTER),
	.BITS(BITS), .SERIAL_STATUS_REGISTER(SERIAL_STATUS_REGISTER), .PCS(PCS), .SCK(SCK),
	.MOSI(MOSI), .MISO(MISO));
